// File: hw/tlb_mm_pkg.sv
// What this block does
// - Longword only; reserved bits write zero.
// - Valid and dirty shared by both views.
// - Instruction address array at F2, index 9:8.
// - Instruction address word: page, valid, space id.
// - Instruction data array 1 at F30.
// - Instruction data 1 field packing.
// - Instruction data array 2: attribute, timing.
// - Unified address array at F6, index 13:8.
// - Address bit 7 selects associative write.
// - Unified address word: page, dirty, valid, id.
// - Unified address read never performs lookup.
// - Non-associative write stores indexed unified entry.
// - Associative single hit updates dirty and valid.
// - Multiple unified hits raise exception instead.
// - Associative write also updates instruction side.
// - Unified data array 1 at F70.
// - Unified data 1 field packing.
// - Unified data array 2 at F78.
// - Exception records address, code, reset branch.
package tlb_mm_pkg;

    localparam logic [7:0]  SEL_INSTR_XLATE_BUFFER_ADDR  = 8'hf2;
    localparam logic [7:0]  SEL_UNIFIED_XLATE_BUFFER_ADDR  = 8'hf6;
    localparam logic [8:0]  SEL_INSTR_XLATE_BUFFER_DATA1 = 9'h1e6;
    localparam logic [8:0]  SEL_INSTR_XLATE_BUFFER_DATA2 = 9'h1e7;
    localparam logic [8:0]  SEL_UNIFIED_XLATE_BUFFER_DATA1 = 9'h1ee;
    localparam logic [8:0]  SEL_UNIFIED_XLATE_BUFFER_DATA2 = 9'h1ef;

    localparam int INSTR_XLATE_BUFFER_ENTRIES = 4;
    localparam int UNIFIED_XLATE_BUFFER_ENTRIES = 64;
    localparam int IDX_LO       = 8;
    localparam int INSTR_XLATE_BUFFER_IDX_HI  = 9;
    localparam int UNIFIED_XLATE_BUFFER_IDX_HI  = 13;
    localparam int ASSOC_BIT    = 7;

    localparam int VPN_HI     = 31;
    localparam int VPN_LO     = 10;
    localparam int DIRTY_BIT  = 9;
    localparam int VALID_BIT  = 8;
    localparam int ADDRESS_SPACE_ID_HI    = 7;
    localparam int ADDRESS_SPACE_ID_LO    = 0;
    localparam int PPN_HI     = 28;
    localparam int PPN_LO     = 10;
    localparam int SZ_HI_BIT  = 7;
    localparam int SZ_LO_BIT  = 4;
    localparam int IPR_BIT    = 6;
    localparam int UPR_HI     = 6;
    localparam int UPR_LO     = 5;
    localparam int CACHE_BIT  = 3;
    localparam int UDIRTY_BIT = 2;
    localparam int SHARE_BIT  = 1;
    localparam int WT_BIT     = 0;
    localparam int TC_BIT     = 3;
    localparam int SA_HI      = 2;
    localparam int SA_LO      = 0;

    localparam logic [31:0] PAGE_ENTRY_HIGH_ADDR = 32'hff00_0000;
    localparam logic [31:0] FAULT_ADDRESS_ADDR   = 32'hff00_000c;
    localparam logic [31:0] EXC_EVENT_ADDR       = 32'hff00_0024;

    localparam logic [7:0]  PAGE_ENTRY_HIGH_RESET = 8'h00;
    localparam logic [31:0] FAULT_ADDRESS_RESET   = 32'h0000_0000;
    localparam logic [11:0] EXC_EVENT_RESET       = 12'h000;
    localparam logic [11:0] EXC_CODE_MULTI_HIT    = 12'h140;
    localparam logic [31:0] RESET_HANDLER_ADDR    = 32'ha000_0000;

endpackage

// File: hw/tlb_mm_access.sv
`timescale 1ns/10ps
module tlb_mm_access
    import tlb_mm_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             MHIT_EXC,
    output logic      [31:0] HANDLER_ADDR
);

    logic [21:0] instr_xlate_buffer_vpn  [INSTR_XLATE_BUFFER_ENTRIES];
    logic [7:0]  instr_xlate_buffer_address_space_id [INSTR_XLATE_BUFFER_ENTRIES];
    logic [18:0] instr_xlate_buffer_ppn  [INSTR_XLATE_BUFFER_ENTRIES];
    logic [1:0]  instr_xlate_buffer_sz   [INSTR_XLATE_BUFFER_ENTRIES];
    logic        instr_xlate_buffer_pr   [INSTR_XLATE_BUFFER_ENTRIES];
    logic        instr_xlate_buffer_c    [INSTR_XLATE_BUFFER_ENTRIES];
    logic        instr_xlate_buffer_sh   [INSTR_XLATE_BUFFER_ENTRIES];
    logic [2:0]  instr_xlate_buffer_sa   [INSTR_XLATE_BUFFER_ENTRIES];
    logic        instr_xlate_buffer_tc   [INSTR_XLATE_BUFFER_ENTRIES];
    logic [INSTR_XLATE_BUFFER_ENTRIES-1:0] instr_xlate_buffer_v_q;

    logic [21:0] unified_xlate_buffer_vpn  [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [7:0]  unified_xlate_buffer_address_space_id [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [18:0] unified_xlate_buffer_ppn  [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [1:0]  unified_xlate_buffer_sz   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [1:0]  unified_xlate_buffer_pr   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic        unified_xlate_buffer_c    [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic        unified_xlate_buffer_sh   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic        unified_xlate_buffer_wt   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [2:0]  unified_xlate_buffer_sa   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic        unified_xlate_buffer_tc   [UNIFIED_XLATE_BUFFER_ENTRIES];
    logic [UNIFIED_XLATE_BUFFER_ENTRIES-1:0] unified_xlate_buffer_v_q;
    logic [UNIFIED_XLATE_BUFFER_ENTRIES-1:0] unified_xlate_buffer_d_q;

    logic [7:0]  page_entry_high_q;
    logic [31:0] fault_address_q;
    logic [11:0] exception_event_q;
    logic [31:0] prdata_q;
    logic        err_q;
    logic        mhit_q;
    logic        mhit_exc_q;

    logic        setup;
    logic        access;
    logic        wr;
    logic        hit_ia;
    logic        hit_id1;
    logic        hit_id2;
    logic        hit_ua;
    logic        hit_ud1;
    logic        hit_ud2;
    logic        hit_peh;
    logic        hit_flt;
    logic        hit_exc;
    logic        mapped;
    logic        assoc;
    logic        bad_size;
    logic [1:0]  ii;
    logic [5:0]  ui;
    logic [21:0] req_vpn;
    logic [UNIFIED_XLATE_BUFFER_ENTRIES-1:0] u_hit;
    logic [INSTR_XLATE_BUFFER_ENTRIES-1:0] i_hit;
    logic        multi;
    logic        single;
    logic [5:0]  u_idx;
    logic [31:0] rd_d;
    logic        err_d;
    logic        do_wr;
    logic        do_assoc;

    function automatic logic vpn_match(input logic [21:0] ent, input logic [21:0] req, input logic [1:0] sz);
        logic [21:0] mask;
        mask = 22'h3fffff;
        case (sz)
            2'b01:   mask = 22'h3ffffc;
            2'b10:   mask = 22'h3fffc0;
            2'b11:   mask = 22'h3ffc00;
            default: mask = 22'h3fffff;
        endcase
        return ((ent ^ req) & mask) == 22'h000000;
    endfunction

    assign setup  = PSEL & ~PENABLE;
    assign access = PSEL & PENABLE;
    assign wr     = access & PWRITE;

    assign hit_ia  = PADDR[31:24] == SEL_INSTR_XLATE_BUFFER_ADDR;
    assign hit_id1 = PADDR[31:23] == SEL_INSTR_XLATE_BUFFER_DATA1;
    assign hit_id2 = PADDR[31:23] == SEL_INSTR_XLATE_BUFFER_DATA2;
    assign hit_ua  = PADDR[31:24] == SEL_UNIFIED_XLATE_BUFFER_ADDR;
    assign hit_ud1 = PADDR[31:23] == SEL_UNIFIED_XLATE_BUFFER_DATA1;
    assign hit_ud2 = PADDR[31:23] == SEL_UNIFIED_XLATE_BUFFER_DATA2;
    assign hit_peh = PADDR == PAGE_ENTRY_HIGH_ADDR;
    assign hit_flt = PADDR == FAULT_ADDRESS_ADDR;
    assign hit_exc = PADDR == EXC_EVENT_ADDR;
    assign mapped  = hit_ia | hit_id1 | hit_id2 | hit_ua | hit_ud1 | hit_ud2 | hit_peh | hit_flt | hit_exc;

    assign ii = PADDR[INSTR_XLATE_BUFFER_IDX_HI:IDX_LO];
    assign ui = PADDR[UNIFIED_XLATE_BUFFER_IDX_HI:IDX_LO];

    assign assoc = hit_ua & PADDR[ASSOC_BIT];

    assign bad_size = PWRITE & (PSTRB != 4'hf);

    assign req_vpn = PWDATA[VPN_HI:VPN_LO];

    always_comb begin
        u_hit = '0;
        for (int k = 0; k < UNIFIED_XLATE_BUFFER_ENTRIES; k++) begin
            u_hit[k] = unified_xlate_buffer_v_q[k] & vpn_match(unified_xlate_buffer_vpn[k], req_vpn, unified_xlate_buffer_sz[k])
                       & (unified_xlate_buffer_sh[k] | (unified_xlate_buffer_address_space_id[k] == page_entry_high_q));
        end
    end

    always_comb begin
        i_hit = '0;
        for (int k = 0; k < INSTR_XLATE_BUFFER_ENTRIES; k++) begin
            i_hit[k] = instr_xlate_buffer_v_q[k] & vpn_match(instr_xlate_buffer_vpn[k], req_vpn, instr_xlate_buffer_sz[k])
                       & (instr_xlate_buffer_sh[k] | (instr_xlate_buffer_address_space_id[k] == page_entry_high_q));
        end
    end

    always_comb begin
        u_idx = 6'h00;
        for (int k = 0; k < UNIFIED_XLATE_BUFFER_ENTRIES; k++) begin
            if (u_hit[k]) begin
                u_idx = k[5:0];
            end
        end
    end

    assign multi  = |(u_hit & (u_hit - 64'h1));
    assign single = (|u_hit) & ~multi;
    assign err_d  = ~mapped | bad_size | (assoc & PWRITE & multi);

    assign do_wr    = wr & ~err_q;
    assign do_assoc = do_wr & assoc;

    always_comb begin
        rd_d = 32'h0000_0000;
        if (!PWRITE) begin
            if (hit_ia) begin
                rd_d = {instr_xlate_buffer_vpn[ii], 1'b0, instr_xlate_buffer_v_q[ii], instr_xlate_buffer_address_space_id[ii]};
            end else if (hit_id1) begin
                rd_d = {3'h0, instr_xlate_buffer_ppn[ii], 1'b0, instr_xlate_buffer_v_q[ii], instr_xlate_buffer_sz[ii][1], instr_xlate_buffer_pr[ii], 1'b0,
                        instr_xlate_buffer_sz[ii][0], instr_xlate_buffer_c[ii], 1'b0, instr_xlate_buffer_sh[ii], 1'b0};
            end else if (hit_id2) begin
                rd_d = {28'h0000000, instr_xlate_buffer_tc[ii], instr_xlate_buffer_sa[ii]};
            end else if (hit_ua) begin
                rd_d = {unified_xlate_buffer_vpn[ui], unified_xlate_buffer_d_q[ui], unified_xlate_buffer_v_q[ui], unified_xlate_buffer_address_space_id[ui]};
            end else if (hit_ud1) begin
                rd_d = {3'h0, unified_xlate_buffer_ppn[ui], 1'b0, unified_xlate_buffer_v_q[ui], unified_xlate_buffer_sz[ui][1], unified_xlate_buffer_pr[ui],
                        unified_xlate_buffer_sz[ui][0], unified_xlate_buffer_c[ui], unified_xlate_buffer_d_q[ui], unified_xlate_buffer_sh[ui], unified_xlate_buffer_wt[ui]};
            end else if (hit_ud2) begin
                rd_d = {28'h0000000, unified_xlate_buffer_tc[ui], unified_xlate_buffer_sa[ui]};
            end else if (hit_peh) begin
                rd_d = {24'h000000, page_entry_high_q};
            end else if (hit_flt) begin
                rd_d = fault_address_q;
            end else if (hit_exc) begin
                rd_d = {20'h00000, exception_event_q};
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
            mhit_q   <= 1'b0;
        end else if (setup) begin
            prdata_q <= rd_d;
            err_q    <= err_d;
            mhit_q   <= assoc & PWRITE & multi & ~bad_size;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            instr_xlate_buffer_v_q <= '0;
        end else if (do_wr) begin
            if (hit_ia || hit_id1) begin
                instr_xlate_buffer_v_q[ii] <= PWDATA[VALID_BIT];
            end else if (do_assoc) begin
                for (int k = 0; k < INSTR_XLATE_BUFFER_ENTRIES; k++) begin
                    if (i_hit[k]) begin
                        instr_xlate_buffer_v_q[k] <= PWDATA[VALID_BIT];
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            unified_xlate_buffer_v_q <= '0;
            unified_xlate_buffer_d_q <= '0;
        end else if (do_wr) begin
            if (hit_ua && !assoc) begin
                unified_xlate_buffer_v_q[ui] <= PWDATA[VALID_BIT];
                unified_xlate_buffer_d_q[ui] <= PWDATA[DIRTY_BIT];
            end else if (do_assoc && single) begin
                unified_xlate_buffer_v_q[u_idx] <= PWDATA[VALID_BIT];
                unified_xlate_buffer_d_q[u_idx] <= PWDATA[DIRTY_BIT];
            end else if (hit_ud1) begin
                unified_xlate_buffer_v_q[ui] <= PWDATA[VALID_BIT];
                unified_xlate_buffer_d_q[ui] <= PWDATA[UDIRTY_BIT];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (do_wr) begin
            if (hit_ia) begin
                instr_xlate_buffer_vpn[ii]  <= PWDATA[VPN_HI:VPN_LO];
                instr_xlate_buffer_address_space_id[ii] <= PWDATA[ADDRESS_SPACE_ID_HI:ADDRESS_SPACE_ID_LO];
            end else if (hit_id1) begin
                instr_xlate_buffer_ppn[ii] <= PWDATA[PPN_HI:PPN_LO];
                instr_xlate_buffer_sz[ii]  <= {PWDATA[SZ_HI_BIT], PWDATA[SZ_LO_BIT]};
                instr_xlate_buffer_pr[ii]  <= PWDATA[IPR_BIT];
                instr_xlate_buffer_c[ii]   <= PWDATA[CACHE_BIT];
                instr_xlate_buffer_sh[ii]  <= PWDATA[SHARE_BIT];
            end else if (hit_id2) begin
                instr_xlate_buffer_sa[ii] <= PWDATA[SA_HI:SA_LO];
                instr_xlate_buffer_tc[ii] <= PWDATA[TC_BIT];
            end else if (do_assoc && single) begin
                for (int k = 0; k < INSTR_XLATE_BUFFER_ENTRIES; k++) begin
                    if (i_hit[k]) begin
                        instr_xlate_buffer_vpn[k]  <= unified_xlate_buffer_vpn[u_idx];
                        instr_xlate_buffer_address_space_id[k] <= unified_xlate_buffer_address_space_id[u_idx];
                        instr_xlate_buffer_ppn[k]  <= unified_xlate_buffer_ppn[u_idx];
                        instr_xlate_buffer_sz[k]   <= unified_xlate_buffer_sz[u_idx];
                        instr_xlate_buffer_pr[k]   <= unified_xlate_buffer_pr[u_idx][1];
                        instr_xlate_buffer_c[k]    <= unified_xlate_buffer_c[u_idx];
                        instr_xlate_buffer_sh[k]   <= unified_xlate_buffer_sh[u_idx];
                        instr_xlate_buffer_sa[k]   <= unified_xlate_buffer_sa[u_idx];
                        instr_xlate_buffer_tc[k]   <= unified_xlate_buffer_tc[u_idx];
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (do_wr) begin
            if (hit_ua && !assoc) begin
                unified_xlate_buffer_vpn[ui]  <= PWDATA[VPN_HI:VPN_LO];
                unified_xlate_buffer_address_space_id[ui] <= PWDATA[ADDRESS_SPACE_ID_HI:ADDRESS_SPACE_ID_LO];
            end else if (hit_ud1) begin
                unified_xlate_buffer_ppn[ui] <= PWDATA[PPN_HI:PPN_LO];
                unified_xlate_buffer_sz[ui]  <= {PWDATA[SZ_HI_BIT], PWDATA[SZ_LO_BIT]};
                unified_xlate_buffer_pr[ui]  <= PWDATA[UPR_HI:UPR_LO];
                unified_xlate_buffer_c[ui]   <= PWDATA[CACHE_BIT];
                unified_xlate_buffer_sh[ui]  <= PWDATA[SHARE_BIT];
                unified_xlate_buffer_wt[ui]  <= PWDATA[WT_BIT];
            end else if (hit_ud2) begin
                unified_xlate_buffer_sa[ui] <= PWDATA[SA_HI:SA_LO];
                unified_xlate_buffer_tc[ui] <= PWDATA[TC_BIT];
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            page_entry_high_q <= PAGE_ENTRY_HIGH_RESET;
        end else if (do_wr && hit_peh) begin
            page_entry_high_q <= PWDATA[ADDRESS_SPACE_ID_HI:ADDRESS_SPACE_ID_LO];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fault_address_q   <= FAULT_ADDRESS_RESET;
            exception_event_q <= EXC_EVENT_RESET;
            mhit_exc_q        <= 1'b0;
        end else begin
            mhit_exc_q <= wr & mhit_q;
            if (wr && mhit_q) begin
                fault_address_q   <= {PWDATA[VPN_HI:VPN_LO], 10'h000};
                exception_event_q <= EXC_CODE_MULTI_HIT;
            end
        end
    end

    assign PRDATA       = prdata_q;
    assign PREADY       = 1'b1;
    assign PSLVERR      = err_q;
    assign MHIT_EXC     = mhit_exc_q;
    assign HANDLER_ADDR = RESET_HANDLER_ADDR;

endmodule

// File: tb/tlb_mm_monitor.sv
`timescale 1ns/10ps
module tlb_mm_monitor
    import tlb_mm_pkg::*;
(
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        MHIT_EXC,
    input wire logic [31:0] HANDLER_ADDR
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    ready_always_a: assert property (PREADY)
        else $error("ready low");
    handler_const_a: assert property (HANDLER_ADDR == 32'ha000_0000)
        else $error("handler address wrong");
    strobe_refused_a: assert property (PSEL && !PENABLE && PWRITE && PSTRB != 4'hf |=> PSLVERR)
        else $error("partial write not refused");
    unmapped_read_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR[31:28] != 4'hf
        |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped read not refused");
    array_read_ok_a: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR[31:24] inside {8'hf2, 8'hf3, 8'hf6, 8'hf7} |=> !PSLVERR)
        else $error("array read refused");
    answer_hold_a: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA) && $stable(PSLVERR))
        else $error("read answer moved");
    mhit_cause_a: assert property (MHIT_EXC |-> $past(PSEL && PENABLE && PWRITE && PSLVERR
        && PADDR[31:24] == SEL_UNIFIED_XLATE_BUFFER_ADDR && PADDR[ASSOC_BIT]))
        else $error("exception without associative write");
    mhit_single_a: assert property (MHIT_EXC |=> !MHIT_EXC)
        else $error("exception pulse too long");
    plain_write_quiet_a: assert property (PSEL && PENABLE && PWRITE && !PADDR[ASSOC_BIT] |=> !MHIT_EXC)
        else $error("exception on plain write");
    mhit_seen_c: cover property (MHIT_EXC);
endmodule

bind tlb_mm_access tlb_mm_monitor mon_u (
    .CLK          (CLK),
    .ARST_N       (ARST_N),
    .PSEL         (PSEL),
    .PENABLE      (PENABLE),
    .PWRITE       (PWRITE),
    .PADDR        (PADDR),
    .PWDATA       (PWDATA),
    .PSTRB        (PSTRB),
    .PRDATA       (PRDATA),
    .PREADY       (PREADY),
    .PSLVERR      (PSLVERR),
    .MHIT_EXC     (MHIT_EXC),
    .HANDLER_ADDR (HANDLER_ADDR)
);

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] ra;
        logic [31:0] m;
    } row_s;
    logic        clk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        mhit_exc;
    logic [31:0] handler_addr;
    logic [31:0] rdata;
    logic        err;
    int          n_fail;
    int          n_compared;
    row_s        rows [6];

    tlb_mm_access dut_u (
        .CLK          (clk),
        .ARST_N       (arst_n),
        .PSEL         (psel),
        .PENABLE      (penable),
        .PWRITE       (pwrite),
        .PADDR        (paddr),
        .PWDATA       (pwdata),
        .PSTRB        (pstrb),
        .PRDATA       (prdata),
        .PREADY       (pready),
        .PSLVERR      (pslverr),
        .MHIT_EXC     (mhit_exc),
        .HANDLER_ADDR (handler_addr)
    );

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0, 4'hf);
        check(rdata & m, exp & m);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        n_fail = 0;
        n_compared = 0;
        rows = '{'{32'hf2000100, 32'h12345567, 32'hf27ff100, 32'hfffffdff},
                 '{32'hf3000100, 32'h0abcd5da, 32'hf3012100, 32'h1ffffdda},
                 '{32'hf3800200, 32'h0000000b, 32'hf38ff200, 32'h0000000f},
                 '{32'hf6003f00, 32'habcde3a5, 32'hf6ffff00, 32'hffffffff},
                 '{32'hf7003f00, 32'h01234dfd, 32'hf7403f00, 32'h1ffffdff},
                 '{32'hf7800000, 32'h0000000d, 32'hf7c000fc, 32'h0000000f}};
        repeat (16) @(posedge clk);
        check(prdata, 32'h0);
        check({30'h0, pslverr, mhit_exc}, 32'h0);
        check(handler_addr, 32'ha000_0000);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].ra, rows[i].d, rows[i].m);
        end
        wr(32'hf7003f00, 32'h01234cf8);
        rd(32'hf6003f00, 32'habcde0a5, 32'hffffffff);
        wr(32'hf6003f00, 32'habcde2a5);
        rd(32'hf7003f00, 32'h01234cfc, 32'h1ffffdff);
        apb(1'b1, 32'hf6003f00, 32'h0, 4'h3);
        check({31'h0, err}, 32'h1);
        rd(32'hf6003f00, 32'habcde2a5, 32'hffffffff);
        rd(32'h40000000, 32'h0, 32'hffffffff);
        check({31'h0, err}, 32'h1);
        wr(32'hff000000, 32'h5);
        wr(32'hf7000a00, 32'h0);
        wr(32'hf6000a00, 32'h40000105);
        wr(32'hf3000000, 32'h0);
        wr(32'hf2000000, 32'h40000105);
        wr(32'hf6000a80, 32'h40000200);
        check({31'h0, err}, 32'h0);
        rd(32'hf6000a00, 32'h40000205, 32'hffffffff);
        rd(32'hf2000000, 32'h40000005, 32'hfffffdff);
        rd(32'hf6000a80, 32'h40000205, 32'hffffffff);
        wr(32'hf6000a00, 32'h40000105);
        wr(32'hf7000b00, 32'h0);
        wr(32'hf6000b00, 32'h40000105);
        wr(32'hf6000a80, 32'h40000300);
        check({31'h0, err}, 32'h1);
        #1;
        check({31'h0, mhit_exc}, 32'h1);
        rd(32'hf6000a00, 32'h40000105, 32'hffffffff);
        rd(32'hff00000c, 32'h40000000, 32'hffffffff);
        rd(32'hff000024, 32'h00000140, 32'h00000fff);
        wr(32'hf2000000, 32'h50000105);
        wr(32'hf6000a80, 32'h50000000);
        check({31'h0, err}, 32'h0);
        rd(32'hf2000000, 32'h50000005, 32'hfffffdff);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        check(prdata, 32'h0);
        arst_n <= 1'b1;
        rd(32'hf2000000, 32'h0, 32'h00000100);
        rd(32'hf6003f00, 32'h0, 32'h00000300);
        wr(32'hf7000c00, 32'h00000092);
        wr(32'hf6000c00, 32'h60000133);
        wr(32'hf6000c80, 32'h600ffe00);
        check({31'h0, err}, 32'h0);
        rd(32'hf6000c00, 32'h60000233, 32'hffffffff);
        rd(32'hf7000c00, 32'h00000096, 32'h1ffffdff);
        complete_run();
    end
endmodule
